// [shared/eeprom_guard_pkg.sv]
package eeprom_guard_pkg;
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int POR_TIMEOUT_MS = 250;
  localparam int POR_CYCLES = POR_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int WRITE_CYCLE_TIME_MS = 5;
  localparam int WC_CYCLES = WRITE_CYCLE_TIME_MS * (CLK_HZ / 1000);
  localparam int LINGER_NS = 200;
  localparam int LINGER_CYCLES = (LINGER_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int TMR_W = 24;
  // array and serial protocol
  localparam int ARRAY_AW = 14;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_AW = 6;
  localparam logic [3:0] ARRAY_TYPE = 4'ha;
  localparam logic [15:0] CTRL_WADDR = 16'hffff;
  localparam logic [7:0] SEQ_WEL = 8'h02;
  localparam logic [7:0] SEQ_ARM = 8'h06;
  localparam logic [7:0] CTRL_RESET = 8'h06;
  localparam int CTRL_PEN_BIT = 7;
  localparam int CTRL_LOCK_LSB = 3;
  // register map
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CTRL = 4'h8;
  localparam logic [1:0] DEVSEL_RESET = 2'h0;
  localparam int STAT_WEL = 0;
  localparam int STAT_ACTIVE = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_RSTOUT = 3;

  typedef enum logic [3:0] {
    ST_STANDBY = 4'h0,
    ST_ADDR = 4'h1,
    ST_WA_HI = 4'h3,
    ST_WA_LO = 4'h2,
    ST_WDATA = 4'h6,
    ST_LINGER = 4'h7,
    ST_RDATA = 4'h5,
    ST_SKIP = 4'h4
  } phase_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avs_req_t;

  typedef struct packed {
    logic we;
    logic [ARRAY_AW-1:0] addr;
    logic [7:0] data;
  } nv_wr_t;

  typedef struct packed {
    phase_t phase;
    logic scl_q;
    logic sda_q;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic tx_go;
    logic ack_pend;
    logic rw;
    logic [7:0] hi;
    logic [ARRAY_AW-1:0] addr;
    logic to_ctrl;
    logic [7:0] ctl_byte;
    logic data_ok;
    logic abort;
    logic [PAGE_AW:0] nbytes;
    logic [ARRAY_AW-1:0] base;
    logic [PAGE_BYTES-1:0][7:0] page;
    logic [PAGE_AW:0] nv_idx;
    logic [PAGE_AW:0] nv_len;
    logic busy;
    logic rst_out;
    logic [TMR_W-1:0] tmr;
    logic [3:0] linger;
    logic [7:0] ctrl;
    logic write_enable_latch;
    logic [1:0] step;
    logic [1:0] devsel;
    logic active;
    logic sda_lvl;
    logic sda_drv;
    logic waitreq;
    logic [31:0] rdata;
    nv_wr_t nv;
  } guard_state_t;
endpackage

// [hw/eeprom_guard.sv]
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
module eeprom_guard
  import eeprom_guard_pkg::*;
#(
  parameter int POR_LEN = POR_CYCLES,
  parameter int WC_LEN = WC_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic wp_i,
  input wire logic [7:0] array_rdata_i,
  input wire avs_req_t avs_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic rst_out_o,
  output logic active_o,
  output logic [ARRAY_AW-1:0] array_addr_o,
  output nv_wr_t nv_o,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);

  generate
    if (POR_LEN < 1 || POR_LEN >= 2**TMR_W || WC_LEN <= PAGE_BYTES ||
        WC_LEN >= 2**TMR_W) begin : g_bad
      $error("eeprom_guard: timer lengths out of range");
    end
  endgenerate

  function automatic logic addr_ok(input logic [7:0] b,
                                   input logic [1:0] sel);
    addr_ok = (b[7:4] == ARRAY_TYPE) && !b[3] && (b[2:1] == sel);
  endfunction

  function automatic logic locked(input logic [ARRAY_AW-1:0] a,
                                  input logic [7:0] c);
    logic [1:0] lk;
    lk = c[CTRL_LOCK_LSB +: 2];
    unique case (lk)
      2'h0: locked = 1'b0;
      2'h1: locked = (a[ARRAY_AW-1 -: 2] == 2'h3);
      2'h2: locked = a[ARRAY_AW-1];
      2'h3: locked = 1'b1;
    endcase
  endfunction

  guard_state_t s;
  guard_state_t next_s;
  logic rise;
  logic fall;
  logic start_ev;
  logic stop_ev;
  logic [7:0] rx_byte;

  assign rise = scl_i & ~s.scl_q;
  assign fall = ~scl_i & s.scl_q;
  assign start_ev = scl_i & s.scl_q & s.sda_q & ~sda_i;
  assign stop_ev = scl_i & s.scl_q & ~s.sda_q & sda_i;
  assign rx_byte = {s.shreg[6:0], sda_i};

  always_comb begin
    logic [PAGE_AW-1:0] pa;
    pa = s.base[PAGE_AW-1:0] + s.nv_idx[PAGE_AW-1:0];
    next_s = s;
    next_s.scl_q = scl_i;
    next_s.sda_q = sda_i;
    next_s.nv.we = 1'b0;
    // register bus: one wait cycle, then the answer
    if ((avs_i.read || avs_i.write) && s.waitreq) begin
      next_s.waitreq = 1'b0;
      next_s.rdata = '0;
      if (avs_i.read) begin
        unique case (avs_i.address)
          REG_CONFIG: next_s.rdata = {30'h0, s.devsel};
          REG_STATUS: begin
            next_s.rdata[STAT_WEL] = s.write_enable_latch;
            next_s.rdata[STAT_ACTIVE] = s.active;
            next_s.rdata[STAT_BUSY] = s.busy;
            next_s.rdata[STAT_RSTOUT] = s.rst_out;
          end
          REG_CTRL: next_s.rdata = {24'h0, s.ctrl};
          default: next_s.rdata = '0;
        endcase
      end
    end else begin
      next_s.waitreq = 1'b1;
      if (avs_i.write && !s.waitreq && avs_i.address == REG_CONFIG &&
          avs_i.byteenable[0]) begin
        next_s.devsel = avs_i.writedata[1:0];
      end
    end
    // supervisor timeout and self-timed write cycle share one timer
    if (s.rst_out) begin
      if (s.tmr == TMR_W'(POR_LEN - 1)) begin
        next_s.rst_out = 1'b0;
        next_s.tmr = '0;
      end else begin
        next_s.tmr = s.tmr + 1'b1;
      end
    end else if (s.busy) begin
      if (s.nv_idx < s.nv_len) begin
        next_s.nv.we = 1'b1;
        next_s.nv.addr = {s.base[ARRAY_AW-1:PAGE_AW], pa};
        next_s.nv.data = s.page[pa];
        next_s.nv_idx = s.nv_idx + 1'b1;
      end
      if (s.tmr == TMR_W'(WC_LEN - 1)) begin
        next_s.busy = 1'b0;
        next_s.tmr = '0;
      end else begin
        next_s.tmr = s.tmr + 1'b1;
      end
    end
    if (s.phase == ST_LINGER) begin
      if (s.linger == 4'(LINGER_CYCLES - 1)) begin
        next_s.phase = ST_STANDBY;
      end else begin
        next_s.linger = s.linger + 1'b1;
      end
    end
    // serial bus engine
    if (s.rst_out) begin
      next_s.phase = ST_STANDBY;
      next_s.sda_drv = 1'b0;
      next_s.ack_pend = 1'b0;
      next_s.tx_go = 1'b0;
    end else if (start_ev) begin
      next_s.phase = ST_ADDR;
      next_s.bitn = '0;
      next_s.ack_pend = 1'b0;
      next_s.tx_go = 1'b0;
      next_s.sda_drv = 1'b0;
    end else if (stop_ev) begin
      next_s.sda_drv = 1'b0;
      next_s.ack_pend = 1'b0;
      next_s.tx_go = 1'b0;
      next_s.linger = '0;
      if (s.phase == ST_WDATA && s.bitn == 4'h1 && s.data_ok &&
          !s.abort) begin
        next_s.phase = ST_STANDBY;
        next_s.busy = 1'b1;
        next_s.tmr = '0;
        next_s.nv_idx = '0;
        next_s.nv_len = s.to_ctrl ? '0 : s.nbytes;
        if (s.to_ctrl) begin
          if (s.step == 2'h2) begin
            if (!(wp_i && s.ctrl[CTRL_PEN_BIT])) begin
              next_s.ctrl = s.ctl_byte;
            end
            next_s.step = 2'h0;
          end else if (s.ctl_byte == SEQ_WEL) begin
            next_s.write_enable_latch = 1'b1;
            next_s.step = 2'h1;
          end else if (s.ctl_byte == SEQ_ARM && s.step == 2'h1) begin
            next_s.step = 2'h2;
          end else begin
            next_s.step = 2'h0;
          end
        end
      end else if (s.phase != ST_STANDBY) begin
        next_s.phase = ST_LINGER;
      end
    end else if (s.phase != ST_STANDBY && s.phase != ST_LINGER) begin
      if (rise && s.bitn == 4'h8) begin
        next_s.bitn = '0;
        next_s.ack_pend = 1'b0;
        unique case (s.phase)
          ST_ADDR: begin
            next_s.phase = s.rw ? ST_RDATA : ST_WA_HI;
            if (s.rw) begin
              next_s.tx = array_rdata_i;
              next_s.tx_go = 1'b1;
              next_s.addr = s.addr + 1'b1;
            end
          end
          ST_WA_HI: next_s.phase = ST_WA_LO;
          ST_WA_LO: begin
            next_s.phase = ST_WDATA;
            next_s.base = s.addr;
            next_s.nbytes = '0;
            next_s.data_ok = 1'b0;
            next_s.abort = 1'b0;
          end
          ST_WDATA: begin
            if (s.ack_pend) begin
              next_s.data_ok = 1'b1;
              if (!s.to_ctrl) begin
                next_s.addr = {s.addr[ARRAY_AW-1:PAGE_AW],
                               s.addr[PAGE_AW-1:0] + 6'h01};
                if (s.nbytes != 7'(PAGE_BYTES)) begin
                  next_s.nbytes = s.nbytes + 1'b1;
                end
              end
            end
          end
          ST_RDATA: begin
            if (!sda_i && s.tx_go) begin
              next_s.tx = array_rdata_i;
              next_s.addr = s.addr + 1'b1;
            end else begin
              next_s.tx_go = 1'b0;
            end
          end
          ST_SKIP: next_s.phase = ST_STANDBY;
          default: next_s.phase = ST_STANDBY;
        endcase
      end else if (rise) begin
        next_s.bitn = s.bitn + 1'b1;
        next_s.shreg = rx_byte;
        if (s.bitn == 4'h7) begin
          unique case (s.phase)
            ST_ADDR: begin
              if (addr_ok(rx_byte, s.devsel) && !s.busy) begin
                next_s.ack_pend = 1'b1;
                next_s.rw = rx_byte[0];
              end else begin
                next_s.phase = ST_SKIP;
              end
            end
            ST_WA_HI: begin
              next_s.hi = rx_byte;
              next_s.ack_pend = 1'b1;
            end
            ST_WA_LO: begin
              next_s.addr = {s.hi[ARRAY_AW-9:0], rx_byte};
              next_s.to_ctrl = ({s.hi, rx_byte} == CTRL_WADDR);
              next_s.ack_pend = 1'b1;
            end
            ST_WDATA: begin
              if (s.to_ctrl) begin
                next_s.ctl_byte = rx_byte;
                next_s.ack_pend = 1'b1;
              end else if (s.write_enable_latch && !locked(s.addr, s.ctrl)) begin
                next_s.page[s.addr[PAGE_AW-1:0]] = rx_byte;
                next_s.ack_pend = 1'b1;
              end else begin
                next_s.abort = 1'b1;
              end
            end
            default: next_s.ack_pend = 1'b0;
          endcase
        end
      end
      if (fall) begin
        next_s.sda_drv = (s.bitn == 4'h8 && s.ack_pend) ||
                         (s.phase == ST_RDATA && s.tx_go &&
                          s.bitn < 4'h8 && !s.tx[7]);
        if (s.phase == ST_RDATA && s.tx_go && s.bitn < 4'h8) begin
          next_s.tx = {s.tx[6:0], 1'b0};
        end
      end
    end
    next_s.active = (next_s.phase != ST_STANDBY) || next_s.busy;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s <= '0;
      s.phase <= ST_STANDBY;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.rst_out <= 1'b1;
      s.write_enable_latch <= 1'b0;
      s.sda_drv <= 1'b0;
      s.ctrl <= CTRL_RESET;
      s.devsel <= DEVSEL_RESET;
      s.waitreq <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign sda_o = s.sda_lvl;
  assign sda_oe_o = s.sda_drv;
  assign rst_out_o = s.rst_out;
  assign active_o = s.active;
  assign array_addr_o = s.addr;
  assign nv_o = s.nv;
  assign avs_readdata_o = s.rdata;
  assign avs_waitrequest_o = s.waitreq;

  // helper ages for the checks below
  logic [TMR_W-1:0] por_age;
  logic [TMR_W-1:0] wc_age;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      por_age <= '0;
      wc_age <= '0;
    end else begin
      if (s.rst_out) begin
        por_age <= por_age + 1'b1;
      end
      wc_age <= s.busy ? wc_age + 1'b1 : '0;
    end
  end

  sequence s_read_stop;
    stop_ev && s.phase == ST_RDATA && !s.rst_out && !s.busy;
  endsequence
  sequence s_quiet8;
    (!start_ev && !stop_ev)[*8];
  endsequence

  property p_power_up;
    @(posedge mclk_i) rst_i |=> (!active_o && !s.write_enable_latch && !sda_oe_o &&
                                 rst_out_o);
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("power-up state wrong");

  property p_por_len;
    @(posedge mclk_i) disable iff (rst_i)
      $fell(rst_out_o) |-> por_age == TMR_W'(POR_LEN);
  endproperty
  a_por_len: assert property (p_por_len)
    else $error("reset output released at wrong time");

  property p_reset_quiet;
    @(posedge mclk_i) disable iff (rst_i)
      rst_out_o |=> (!sda_oe_o && s.phase == ST_STANDBY && !s.ack_pend);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("bus served during reset output");

  property p_write_needs_latch;
    @(posedge mclk_i) disable iff (rst_i)
      ($rose(s.busy) && s.nv_len != '0) |-> $past(s.write_enable_latch);
  endproperty
  a_write_needs_latch: assert property (p_write_needs_latch)
    else $error("array write without latch");

  property p_midbyte_stop;
    @(posedge mclk_i) disable iff (rst_i)
      (stop_ev && s.phase == ST_WDATA && s.bitn != 4'h1) |=> !$rose(s.busy);
  endproperty
  a_midbyte_stop: assert property (p_midbyte_stop)
    else $error("write started by malformed stop");

  property p_ctrl_guard;
    @(posedge mclk_i) disable iff (rst_i)
      $changed(s.ctrl) |-> $past(s.step == 2'h2 &&
                                 !(wp_i && s.ctrl[CTRL_PEN_BIT]));
  endproperty
  a_ctrl_guard: assert property (p_ctrl_guard)
    else $error("control register changed without guard");

  property p_lock_nack;
    @(posedge mclk_i) disable iff (rst_i)
      (rise && !start_ev && !stop_ev && !s.rst_out &&
       s.phase == ST_WDATA && s.bitn == 4'h7 && !s.to_ctrl &&
       locked(s.addr, s.ctrl)) |=> (!s.ack_pend && s.abort);
  endproperty
  a_lock_nack: assert property (p_lock_nack)
    else $error("locked region acknowledged");

  property p_mismatch_sleep;
    @(posedge mclk_i) disable iff (rst_i)
      (rise && s.phase == ST_SKIP && s.bitn == 4'h8 && !start_ev &&
       !stop_ev && !s.rst_out) |=> s.phase == ST_STANDBY;
  endproperty
  a_mismatch_sleep: assert property (p_mismatch_sleep)
    else $error("no standby after address mismatch");

  property p_read_linger;
    @(posedge mclk_i) disable iff (rst_i)
      s_read_stop ##1 s_quiet8 |=> !active_o;
  endproperty
  a_read_linger: assert property (p_read_linger)
    else $error("standby not reached after read stop");

  property p_busy_len;
    @(posedge mclk_i) disable iff (rst_i)
      $fell(s.busy) |-> (wc_age == TMR_W'(WC_LEN) && $past(active_o));
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle length wrong");

  property p_busy_nack;
    @(posedge mclk_i) disable iff (rst_i)
      (rise && s.phase == ST_ADDR && s.bitn == 4'h7 && s.busy &&
       !start_ev && !stop_ev && !s.rst_out) |=> !s.ack_pend;
  endproperty
  a_busy_nack: assert property (p_busy_nack)
    else $error("address acknowledged while busy");
endmodule

// [tb/serial_host_model.sv]
`timescale 1ns/1ps
module serial_host_model (
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // clock idles high between frames, data released to the pull-up
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic hc();
    repeat (8) @(posedge mclk_i);
  endtask
  task automatic start();
    sda_oe_o <= 1'b0;
    hc();
    scl_o <= 1'b1;
    hc();
    sda_oe_o <= 1'b1;
    hc();
    scl_o <= 1'b0;
    hc();
  endtask
  task automatic stop();
    sda_oe_o <= 1'b1;
    hc();
    scl_o <= 1'b1;
    hc();
    sda_oe_o <= 1'b0;
    hc();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_oe_o <= !b;
    hc();
    scl_o <= 1'b1;
    hc();
    r = sda_i;
    scl_o <= 1'b0;
    hc();
  endtask
  // partial byte, msb first, for aborted transfers
  task automatic bits(input logic [7:0] d, input int n);
    logic r;
    for (int i = 0; i < n; i++) bit_io(d[7-i], r);
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    bits(d, 8);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!more, r);
  endtask
endmodule

// [tb/eeprom_write_guard_power_state_tb.sv]
`timescale 1ns/1ps
module eeprom_write_guard_power_state_tb;
  import eeprom_guard_pkg::*;
  localparam int POR = 600;
  localparam int WC = 400;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wp = 1'b0;
  avs_req_t req = '0;
  logic scl, m_oe, d_oe, sda, d_sda, rst_out, active, waitreq;
  logic [ARRAY_AW-1:0] aaddr;
  nv_wr_t nv;
  logic [31:0] rdata, q, wd;
  logic [7:0] mem [0:16383];
  logic [7:0] ref_mem [0:16383];
  logic [7:0] m_ctrl = CTRL_RESET;
  logic [7:0] d;
  logic [15:0] a;
  logic m_wel = 1'b0;
  logic k;
  logic [1:0] ds;
  int m_step = 0;
  int seed = 32'h9860117f;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int t0;
  logic [21:0] exp_q [$];
  assign sda = !(m_oe | d_oe);
  always #12.5 mclk_i = !mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;
  eeprom_guard #(.POR_LEN(POR), .WC_LEN(WC)) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .wp_i(wp),
    .array_rdata_i(mem[aaddr]), .avs_i(req), .sda_o(d_sda),
    .sda_oe_o(d_oe), .rst_out_o(rst_out), .active_o(active),
    .array_addr_o(aaddr), .nv_o(nv), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq));
  serial_host_model m_u (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl),
    .sda_oe_o(m_oe));
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic av(input logic w, input logic [3:0] ad,
                    input logic [31:0] dw, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk_i);
    req.read <= !w;
    req.write <= w;
    req.address <= ad;
    req.byteenable <= 4'hf;
    req.writedata <= dw;
    do begin
      @(posedge mclk_i);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    r = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (n >= 50) chk(0, 1);
  endtask
  // wait out the self-timed cycle before the next access
  task automatic idle();
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      av(1'b0, REG_STATUS, 0, r);
      n++;
    end while (r[STAT_BUSY] !== 1'b0 && n < 500);
    chk(n < 500, 1);
  endtask
  function automatic logic locked(input logic [13:0] x);
    return m_ctrl[4:3] == 3 || (m_ctrl[4:3] == 2 && x[13]) ||
           (m_ctrl[4:3] == 1 && x[13:12] == 2'b11);
  endfunction
  task automatic addr3(input logic [15:0] x);
    logic a1, a2, a3;
    m_u.start();
    m_u.put({ARRAY_TYPE, 1'b0, ds, 1'b0}, a1);
    m_u.put(x[15:8], a2);
    m_u.put(x[7:0], a3);
    chk({a1, a2, a3}, 3'b111);
  endtask
  task automatic wr(input logic [15:0] x, input logic [7:0] v,
                    input logic poll);
    logic ok, e, p;
    logic [31:0] r;
    addr3(x);
    m_u.put(v, ok);
    e = m_wel && !locked(x[13:0]);
    if (x != CTRL_WADDR) begin
      chk(ok, e);
      if (e) begin
        ref_mem[x[13:0]] = v;
        exp_q.push_back({x[13:0], v});
      end
    end
    m_u.stop();
    if (poll) begin
      m_u.start();
      m_u.put({ARRAY_TYPE, 1'b0, ds, 1'b0}, p);
      chk({p, active}, 2'b01);
      m_u.stop();
    end
    idle();
    repeat (4) @(posedge mclk_i);
    chk(active, 0);
    if (x == CTRL_WADDR) begin
      if (m_step == 2) begin
        if (!(wp && m_ctrl[CTRL_PEN_BIT])) m_ctrl = v;
        m_step = 0;
      end else if (v == SEQ_WEL) begin
        m_wel = 1'b1;
        m_step = 1;
      end else if (v == SEQ_ARM && m_step == 1) m_step = 2;
      else m_step = 0;
      av(1'b0, REG_CTRL, 0, r);
      chk(r[7:0], m_ctrl);
    end
  endtask
  task automatic seq(input logic [7:0] v);
    wr(CTRL_WADDR, SEQ_WEL, 1'b0);
    wr(CTRL_WADDR, SEQ_ARM, 1'b0);
    wr(CTRL_WADDR, v, 1'b0);
  endtask
  task automatic rd(input logic [15:0] x);
    logic p;
    logic [7:0] v;
    addr3(x);
    m_u.start();
    m_u.put({ARRAY_TYPE, 1'b0, ds, 1'b1}, p);
    m_u.get(1'b0, v);
    m_u.stop();
    chk({p, v}, {1'b1, ref_mem[x[13:0]]});
    repeat (4) @(posedge mclk_i);
    chk(active, 0);
  endtask
  always @(posedge mclk_i) begin
    if (nv.we === 1'b1) begin
      mem[nv.addr] <= nv.data;
      if (exp_q.size() == 0) chk(1, 0);
      else chk({nv.addr, nv.data}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (90000) @(posedge mclk_i);
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    t0 = cyc;
    @(posedge mclk_i);
    chk({rst_out, active, d_oe, d_sda}, 4'b1000);
    av(1'b0, REG_STATUS, 0, q);
    chk(q[3:0], 4'b1000);
    m_u.start();
    m_u.put({ARRAY_TYPE, 1'b0, 2'b00, 1'b0}, k);
    m_u.stop();
    chk({k, active}, 2'b00);
    while (rst_out !== 1'b0 && cyc - t0 < 2 * POR) @(posedge mclk_i);
    chk(cyc - t0 >= POR && cyc - t0 <= POR + 3, 1);
    wd = $random(seed);
    ds = wd[1:0];
    av(1'b1, REG_CONFIG, wd, q);
    av(1'b0, REG_CONFIG, 0, q);
    chk(q[1:0], ds);
    av(1'b0, 4'hc, 0, q);
    chk(q, 0);
    a = {2'b00, 14'($random(seed))};
    wr(a, 8'($random(seed)), 1'b0);
    wr(CTRL_WADDR, SEQ_WEL, 1'b0);
    a = {4'h0, 12'($random(seed))};
    wr(a, 8'($random(seed)), 1'b1);
    rd(a);
    addr3(a);
    m_u.bits(~ref_mem[a[13:0]], 4);
    m_u.stop();
    addr3(a);
    m_u.stop();
    rd(a);
    m_u.start();
    repeat (2) @(posedge mclk_i);
    chk(active, 1);
    m_u.put({ARRAY_TYPE, 1'b0, ~ds, 1'b0}, k);
    repeat (4) @(posedge mclk_i);
    chk({k, active}, 2'b00);
    m_u.stop();
    for (int l = 0; l < 4; l++) begin
      seq({3'b000, 2'(l), 3'b000});
      wr({4'h3, 12'($random(seed))}, 8'($random(seed)), 1'b0);
      wr({4'h0, 12'($random(seed))}, 8'($random(seed)), 1'b0);
    end
    seq(8'h98);
    wp <= 1'b1;
    seq(8'h00);
    wp <= 1'b0;
    wr(CTRL_WADDR, SEQ_WEL, 1'b0);
    wr(CTRL_WADDR, 8'h00, 1'b0);
    seq(8'h00);
    wr({2'b00, 14'($random(seed))}, 8'($random(seed)), 1'b0);
    chk(exp_q.size(), 0);
    complete_run();
  end
endmodule
